// ### rtl/dsr_top.sv
// dual-channel serial readout with nap and sleep power-state control
`timescale 1ns/1ps
`include "dsr_params.svh"
// What this block does
// - each falling serial clock edge presents the next result bit, msb first
// - device drives an echoed clock skew-matched to the data outputs
// - echoed positive clock is off when its negative pin is tied high
// - two strobes with idle serial clock enter nap on second rising edge
// - nap ends on a serial clock rising edge or further strobes
// - in nap, two more idle-clock strobes enter sleep
// - in cmos mode one serial clock rising edge ends sleep
// - in lvds mode the fifth strobe ends sleep
// - after waking, serial clock pulses keep the device out of nap
// - fifth-strobe wake also works in cmos mode
// - strobes without serial clock cycle operate, nap, sleep forever
// - cmos: positive pins used, negative pins undriven and pulled low
// - lvds: data and echoed clock driven as differential pairs
// - strobe rise tracks unless it enters or falls in nap, or serial clock rises with it outside lvds sleep; strobe fall holds and converts
module dsr_top (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic sck_in,
   input wire logic convert_strobe_in,
   input wire logic interface_lvds_in,
   input wire logic echo_clk_n_tied_in,
   input wire logic [`DSR_RESULT_W-1:0] ch1_result_in,
   input wire logic [`DSR_RESULT_W-1:0] ch2_result_in,
   output logic channel1_serial_p_out,
   output logic channel1_serial_n_out,
   output logic channel2_serial_p_out,
   output logic channel2_serial_n_out,
   output logic echoed_data_clock_p_out,
   output logic echoed_data_clock_n_out,
   output logic neg_pins_oe_out,
   output logic track_out,
   output logic nap_out,
   output logic sleep_out
);

   dsr_pkg::dsr_core_type core_q;
   dsr_pkg::dsr_core_type core_d;
   logic sck_act_tgl;
   logic so1;
   logic so2;
   logic cnv_rise;
   logic cnv_fall;
   logic sck_rise;
   logic lvds;
   logic tie;
   logic [`DSR_CNT_W-1:0] cnt_inc;

   // =======================================================
   // link-side shifter on the serial clock
   dsr_shifter u_shifter (
      .sck_in(sck_in),
      .rst_n_in(rst_n_in),
      .load_tgl_in(core_q.load_tgl),
      .word1_in(core_q.out1),
      .word2_in(core_q.out2),
      .sck_act_tgl_out(sck_act_tgl),
      .serial1_out(so1),
      .serial2_out(so2)
   );

   // =======================================================
   // events seen from the system clock
   assign cnv_rise = core_q.cnv_s2 & ~core_q.cnv_s3;
   assign cnv_fall = ~core_q.cnv_s2 & core_q.cnv_s3;
   // one toggle per rising serial clock edge; bursts faster than the
   // system clock merge, and an even number of edges within one sample leaves no toggle, so no activity is seen
   assign sck_rise = core_q.act_s2 ^ core_q.act_s3;
   assign lvds = core_q.sel_s2;
   assign tie = core_q.tie_s2;
   assign cnt_inc = `DSR_CNT_W'(core_q.cnt + `DSR_CNT_ONE);

   // =======================================================
   // power state and conversion control
   always_comb begin
      core_d = core_q;
      core_d.cnv_s1 = convert_strobe_in;
      core_d.cnv_s2 = core_q.cnv_s1;
      core_d.cnv_s3 = core_q.cnv_s2;
      core_d.sel_s1 = interface_lvds_in;
      core_d.sel_s2 = core_q.sel_s1;
      core_d.tie_s1 = echo_clk_n_tied_in;
      core_d.tie_s2 = core_q.tie_s1;
      core_d.act_s1 = sck_act_tgl;
      core_d.act_s2 = core_q.act_s1;
      core_d.act_s3 = core_q.act_s2;
      unique case (core_q.power)
         dsr_pkg::PWR_OPER: begin
            if (sck_rise) begin
               core_d.cnt = `DSR_CNT_ZERO;
            end else if (cnv_rise) begin
               core_d.cnt = cnt_inc;
               if (cnt_inc == `DSR_NAP_COUNT) begin
                  core_d.power = dsr_pkg::PWR_NAP;
               end else begin
                  core_d.track = 1'b1;
               end
            end
         end
         dsr_pkg::PWR_NAP: begin
            if (sck_rise) begin
               core_d.power = dsr_pkg::PWR_OPER;
               core_d.cnt = `DSR_CNT_ZERO;
            end else if (cnv_rise) begin
               core_d.cnt = cnt_inc;
               if (cnt_inc == `DSR_SLEEP_COUNT) begin
                  core_d.power = dsr_pkg::PWR_SLEEP;
               end
            end
         end
         dsr_pkg::PWR_SLEEP: begin
            if (sck_rise && !lvds) begin
               core_d.power = dsr_pkg::PWR_OPER;
               core_d.cnt = `DSR_CNT_ZERO;
            end else if (cnv_rise) begin
               if (cnt_inc == `DSR_WAKE_COUNT) begin
                  // the count restarts, so idle strobes go round again
                  core_d.power = dsr_pkg::PWR_OPER;
                  core_d.cnt = `DSR_CNT_ZERO;
                  core_d.track = 1'b1;
               end else begin
                  core_d.cnt = cnt_inc;
               end
            end
         end
         default: begin
            core_d.power = dsr_pkg::PWR_OPER;
            core_d.cnt = `DSR_CNT_ZERO;
         end
      endcase
      // hold edge: the word sent next is the previous conversion
      if (cnv_fall && core_q.track) begin
         core_d.track = 1'b0;
         core_d.out1 = core_q.conv1;
         core_d.out2 = core_q.conv2;
         core_d.conv1 = ch1_result_in;
         core_d.conv2 = ch2_result_in;
         core_d.load_tgl = ~core_q.load_tgl;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core_q <= dsr_pkg::DSR_CORE_RST;
      end else begin
         core_q <= core_d;
      end
   end

   // =======================================================
   // pins
   assign channel1_serial_p_out = so1;
   assign channel2_serial_p_out = so2;
   // negative pins stay low (pull-down level) and undriven in cmos mode
   assign channel1_serial_n_out = lvds & ~so1;
   assign channel2_serial_n_out = lvds & ~so2;
   assign neg_pins_oe_out = lvds;
   // gated only by a static strap, so no glitch reaches the clock
   assign echoed_data_clock_p_out = sck_in & ~tie;
   assign echoed_data_clock_n_out = lvds & ~sck_in;
   assign track_out = core_q.track;
   assign nap_out = core_q.power == dsr_pkg::PWR_NAP;
   assign sleep_out = core_q.power == dsr_pkg::PWR_SLEEP;

   // =======================================================
   // checks
   property p_nap_entry;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (core_q.power == dsr_pkg::PWR_OPER && cnv_rise && !sck_rise &&
         core_q.cnt == `DSR_CNT_ONE) |=> nap_out && !track_out;
   endproperty
   a_nap_entry: assert property (p_nap_entry)
      else $error("second idle strobe did not enter nap");

   property p_nap_sck_wake;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (nap_out && sck_rise) |=> !nap_out && !sleep_out &&
         core_q.cnt == `DSR_CNT_ZERO;
   endproperty
   a_nap_sck_wake: assert property (p_nap_sck_wake)
      else $error("serial clock edge did not end nap");

   property p_sleep_entry;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (nap_out && cnv_rise && !sck_rise &&
         core_q.cnt == 3'h3) |=> sleep_out;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("two more strobes in nap did not enter sleep");

   property p_cmos_wake;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (sleep_out && sck_rise && !lvds) |=> !sleep_out && !nap_out;
   endproperty
   a_cmos_wake: assert property (p_cmos_wake)
      else $error("cmos serial clock edge did not end sleep");

   property p_lvds_sleep_hold;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (sleep_out && lvds && !cnv_rise) |=> sleep_out;
   endproperty
   a_lvds_sleep_hold: assert property (p_lvds_sleep_hold)
      else $error("lvds sleep left without a strobe");

   property p_fifth_wake;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (sleep_out && cnv_rise && !(sck_rise && !lvds)) |=>
         !sleep_out && track_out && core_q.cnt == `DSR_CNT_ZERO;
   endproperty
   a_fifth_wake: assert property (p_fifth_wake)
      else $error("fifth strobe did not wake the device");

   property p_sck_keeps_awake;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!nap_out && !sleep_out && sck_rise) |=>
         core_q.cnt == `DSR_CNT_ZERO ##1 !nap_out;
   endproperty
   a_sck_keeps_awake: assert property (p_sck_keeps_awake)
      else $error("serial clock activity did not clear the count");

   property p_track_then_hold;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (track_out && cnv_fall) |=> !track_out &&
         core_q.out1 == $past(core_q.conv1) &&
         core_q.load_tgl != $past(core_q.load_tgl);
   endproperty
   a_track_then_hold: assert property (p_track_then_hold)
      else $error("hold edge did not hand over the previous result");

   property p_echo_gate;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      tie |-> !echoed_data_clock_p_out;
   endproperty
   a_echo_gate: assert property (p_echo_gate)
      else $error("echoed clock driven while its negative pin is tied");

   property p_cmos_neg_quiet;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !lvds |-> !neg_pins_oe_out && !channel1_serial_n_out &&
         !channel2_serial_n_out && !echoed_data_clock_n_out;
   endproperty
   a_cmos_neg_quiet: assert property (p_cmos_neg_quiet)
      else $error("negative pins active in cmos mode");

   property p_nap_holds;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (nap_out && !sck_rise && !cnv_rise) |=> nap_out;
   endproperty
   a_nap_holds: assert property (p_nap_holds)
      else $error("nap left without a strobe or serial clock edge");

   property p_nap_no_track;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (nap_out && cnv_rise) |=> !track_out;
   endproperty
   a_nap_no_track: assert property (p_nap_no_track)
      else $error("strobe in nap started tracking");

   property p_sleep_holds;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (sleep_out && !cnv_rise && !sck_rise) |=> sleep_out;
   endproperty
   a_sleep_holds: assert property (p_sleep_holds)
      else $error("sleep left without a strobe or serial clock edge");

   property p_first_strobe_tracks;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!nap_out && !sleep_out && cnv_rise && !sck_rise &&
         core_q.cnt == `DSR_CNT_ZERO) |=> track_out && !nap_out;
   endproperty
   a_first_strobe_tracks: assert property (p_first_strobe_tracks)
      else $error("first idle strobe did not start tracking");

   property p_hold_capture;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (track_out && cnv_fall) |=> core_q.conv1 == $past(ch1_result_in) &&
         core_q.conv2 == $past(ch2_result_in) &&
         core_q.out2 == $past(core_q.conv2);
   endproperty
   a_hold_capture: assert property (p_hold_capture)
      else $error("hold edge did not capture both channel results");

   property p_nap_count;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      nap_out |-> core_q.cnt == `DSR_NAP_COUNT || core_q.cnt == 3'h3;
   endproperty
   a_nap_count: assert property (p_nap_count)
      else $error("nap held with a strobe count outside two and three");

   property p_sleep_count;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      sleep_out |-> core_q.cnt == `DSR_SLEEP_COUNT;
   endproperty
   a_sleep_count: assert property (p_sleep_count)
      else $error("sleep held without four counted strobes");

   property p_lvds_pairs;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      lvds |-> neg_pins_oe_out &&
         channel1_serial_n_out != channel1_serial_p_out &&
         channel2_serial_n_out != channel2_serial_p_out;
   endproperty
   a_lvds_pairs: assert property (p_lvds_pairs)
      else $error("lvds data pair not driven as complements");

endmodule

// ### rtl/dsr_params.svh
// constants for the dual-channel serial readout and power-state block
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// result word: 12 bits plus sign
`define DSR_RESULT_W 13
`define DSR_CNT_W 3

// strobe counts, taken with the serial clock idle
`define DSR_CNT_ZERO 3'h0
`define DSR_CNT_ONE 3'h1
`define DSR_NAP_COUNT 3'h2
`define DSR_SLEEP_COUNT 3'h4
`define DSR_WAKE_COUNT 3'h5

// one-hot power state codes
`define DSR_PWR_OPER 3'h1
`define DSR_PWR_NAP 3'h2
`define DSR_PWR_SLEEP 3'h4

`endif

// ### rtl/dsr_pkg.sv
// types shared by the serial readout core and its link-side shifter
package dsr_pkg;
`include "dsr_params.svh"

   typedef enum logic [2:0] {
      PWR_OPER = `DSR_PWR_OPER,
      PWR_NAP = `DSR_PWR_NAP,
      PWR_SLEEP = `DSR_PWR_SLEEP
   } dsr_power_type;

   typedef struct packed {
      logic cnv_s1;
      logic cnv_s2;
      logic cnv_s3;
      logic sel_s1;
      logic sel_s2;
      logic tie_s1;
      logic tie_s2;
      logic act_s1;
      logic act_s2;
      logic act_s3;
      dsr_power_type power;
      logic [`DSR_CNT_W-1:0] cnt;
      logic track;
      logic load_tgl;
      logic [`DSR_RESULT_W-1:0] conv1;
      logic [`DSR_RESULT_W-1:0] conv2;
      logic [`DSR_RESULT_W-1:0] out1;
      logic [`DSR_RESULT_W-1:0] out2;
   } dsr_core_type;

   localparam dsr_core_type DSR_CORE_RST = '{power: PWR_OPER, default: '0};

   typedef struct packed {
      logic act_tgl;
   } dsr_rise_type;

   typedef struct packed {
      logic ld_s1;
      logic ld_s2;
      logic ld_seen;
      logic [`DSR_RESULT_W-1:0] sh1;
      logic [`DSR_RESULT_W-1:0] sh2;
      logic so1;
      logic so2;
   } dsr_fall_type;

endpackage

// ### rtl/dsr_shifter.sv
// serial-clock-domain logic: result shifting and clock activity toggle
`timescale 1ns/1ps
`include "dsr_params.svh"
module dsr_shifter (
   input wire logic sck_in,
   input wire logic rst_n_in,
   input wire logic load_tgl_in,
   input wire logic [`DSR_RESULT_W-1:0] word1_in,
   input wire logic [`DSR_RESULT_W-1:0] word2_in,
   output logic sck_act_tgl_out,
   output logic serial1_out,
   output logic serial2_out
);

   dsr_pkg::dsr_rise_type rise_q;
   dsr_pkg::dsr_rise_type rise_d;
   dsr_pkg::dsr_fall_type fall_q;
   dsr_pkg::dsr_fall_type fall_d;
   logic new_word;
   logic [`DSR_RESULT_W:0] step1;
   logic [`DSR_RESULT_W:0] step2;

   // returns {bit to present, remaining shift contents}
   function automatic logic [`DSR_RESULT_W:0] shift_step(
      input logic load,
      input logic [`DSR_RESULT_W-1:0] word,
      input logic [`DSR_RESULT_W-1:0] sh
   );
      logic [`DSR_RESULT_W-1:0] src;
      src = load ? word : sh;
      shift_step = {src[`DSR_RESULT_W-1], src[`DSR_RESULT_W-2:0], 1'b0};
   endfunction

   // =======================================================
   // rising edges: activity toggle for the power-state logic
   always_comb begin
      rise_d = rise_q;
      rise_d.act_tgl = ~rise_q.act_tgl;
   end

   always_ff @(posedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rise_q <= '0;
      end else begin
         rise_q <= rise_d;
      end
   end

   // =======================================================
   // falling edges: msb-first shifting
   // the word is held still by the core until long after the toggle
   // settles, so it is sampled directly once the toggle is seen
   assign new_word = fall_q.ld_s2 != fall_q.ld_seen;
   assign step1 = shift_step(new_word, word1_in, fall_q.sh1);
   assign step2 = shift_step(new_word, word2_in, fall_q.sh2);

   always_comb begin
      fall_d = fall_q;
      fall_d.ld_s1 = load_tgl_in;
      fall_d.ld_s2 = fall_q.ld_s1;
      fall_d.ld_seen = fall_q.ld_s2;
      fall_d.so1 = step1[`DSR_RESULT_W];
      fall_d.sh1 = step1[`DSR_RESULT_W-1:0];
      fall_d.so2 = step2[`DSR_RESULT_W];
      fall_d.sh2 = step2[`DSR_RESULT_W-1:0];
   end

   always_ff @(negedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fall_q <= '0;
      end else begin
         fall_q <= fall_d;
      end
   end

   assign sck_act_tgl_out = rise_q.act_tgl;
   assign serial1_out = fall_q.so1;
   assign serial2_out = fall_q.so2;

   // =======================================================
   // checks
   property p_shift_msb_next;
      @(negedge sck_in) disable iff (!rst_n_in)
      !new_word |=> fall_q.so1 == $past(fall_q.sh1[`DSR_RESULT_W-1]);
   endproperty
   a_shift_msb_next: assert property (p_shift_msb_next)
      else $error("serial bit is not the next shifted bit");

   property p_load_msb;
      @(negedge sck_in) disable iff (!rst_n_in)
      new_word |=> fall_q.so2 == $past(word2_in[`DSR_RESULT_W-1]);
   endproperty
   a_load_msb: assert property (p_load_msb)
      else $error("new word did not start with its msb");

endmodule

// ### sim/dsr_host_model.sv
// host-side model: serial clock bursts and capture of both data lines
`timescale 1ns/1ps
`include "dsr_params.svh"
module dsr_host_model (
   output logic sck_out,
   input wire logic data1_in,
   input wire logic data2_in,
   input wire logic echo_in
);
   int echo_ones;
   // clock stands low between frames, so idle strobes are seen as idle
   initial begin
      sck_out = 1'b0;
      echo_ones = 0;
   end
   // ==========================================================
   // frame: two sync falls, then 13 bits taken on rising edges
   task automatic frame(output logic [`DSR_RESULT_W-1:0] w1,
                        output logic [`DSR_RESULT_W-1:0] w2);
      echo_ones = 0;
      w1 = '0;
      w2 = '0;
      for (int i = 0; i < 16; i++) begin
         #32 sck_out = 1'b1;
         if (i > 2) begin
            w1 = {w1[`DSR_RESULT_W-2:0], data1_in};
            w2 = {w2[`DSR_RESULT_W-2:0], data2_in};
         end
         #8;
         if (echo_in === 1'b1) begin
            echo_ones++;
         end
         #24 sck_out = 1'b0;
      end
   endtask
endmodule

// ### sim/dsr_top_bench.sv
// self-checking bench for the serial readout and power-state block
`timescale 1ns/1ps
`include "dsr_params.svh"
module dsr_top_bench;
   localparam int W = `DSR_RESULT_W;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strobe = 1'b0;
   logic lvds = 1'b0;
   logic tie = 1'b0;
   logic [W-1:0] ch1 = '0;
   logic [W-1:0] ch2 = '0;
   logic sck, d1p, d1n, d2p, d2n, ep, en, oe, trk, nap, slp;
   int st, cnt, m, fail_count, samples_checked;
   logic [W-1:0] q1[$];
   logic [W-1:0] q2[$];

   dsr_top dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .sck_in(sck),
      .convert_strobe_in(strobe), .interface_lvds_in(lvds),
      .echo_clk_n_tied_in(tie), .ch1_result_in(ch1),
      .ch2_result_in(ch2), .channel1_serial_p_out(d1p),
      .channel1_serial_n_out(d1n), .channel2_serial_p_out(d2p),
      .channel2_serial_n_out(d2n), .echoed_data_clock_p_out(ep),
      .echoed_data_clock_n_out(en), .neg_pins_oe_out(oe),
      .track_out(trk), .nap_out(nap), .sleep_out(slp));
   dsr_host_model host_u (.sck_out(sck), .data1_in(d1p),
      .data2_in(d2p), .echo_in(ep));

   initial begin
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // checking
   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_word(input string n, input logic [W-1:0] e,
                           input logic [W-1:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_state(input logic t);
      chk_bit("nap", st == 1, nap);
      chk_bit("sleep", st == 2, slp);
      chk_bit("track", t, trk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // pin levels while the serial clock is high
   always @(posedge sck) begin
      #4;
      chk_bit("ch1_n", lvds ? ~d1p : 1'b0, d1n);
      chk_bit("ch2_n", lvds ? ~d2p : 1'b0, d2n);
      chk_bit("neg_oe", lvds, oe);
      chk_bit("echo_n", 1'b0, en);
   end
   // pin levels while the serial clock is low
   always @(negedge sck) begin
      #4;
      chk_bit("echo_n_low", lvds, en);
      chk_bit("echo_p_low", 1'b0, ep);
   end
   // ==========================================================
   // stimulus and reference model
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      st = 0;
      cnt = 0;
      q1 = '{'0};
      q2 = '{'0};
      repeat (4) @(posedge clk);
      #1;
      chk_state(1'b0);
   endtask
   task automatic pulse();
      logic [W-1:0] a, b;
      logic t;
      a = W'($urandom);
      b = W'($urandom);
      @(posedge clk);
      ch1 <= a;
      ch2 <= b;
      strobe <= 1'b1;
      q1.push_back(a);
      q2.push_back(b);
      t = 1'b0;
      if (st == 0) begin
         cnt++;
         if (cnt == 2)
            st = 1;
         else
            t = 1'b1;
      end else if (st == 1) begin
         cnt++;
         if (cnt == 4)
            st = 2;
      end else begin
         st = 0;
         cnt = 0;
         t = 1'b1;
      end
      repeat (6) @(posedge clk);
      #1;
      chk_state(t);
      @(posedge clk);
      strobe <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk_state(1'b0);
   endtask
   task automatic frame(input bit dat);
      logic [W-1:0] w1, w2;
      host_u.frame(w1, w2);
      if (!(st == 2 && m == 1)) begin
         st = 0;
         cnt = 0;
      end
      repeat (6) @(posedge clk);
      #1;
      chk_state(1'b0);
      chk_word("echo", tie ? 0 : 16, host_u.echo_ones);
      if (dat) begin
         chk_word("word1", q1[q1.size() - 2], w1);
         chk_word("word2", q2[q2.size() - 2], w2);
      end
   endtask

   initial begin
      void'($urandom(32'h60EF));
      for (m = 0; m < 2; m++) begin
         @(posedge clk);
         lvds <= m[0];
         tie <= m[0];
         do_reset();
         repeat (4) begin
            pulse();
            frame(1'b1);
         end
         repeat (10) pulse();
         repeat (2) pulse();
         frame(1'b0);
         repeat (4) pulse();
         // no conversion is trusted straight after a sleep wake
         frame(1'b0);
         pulse();
         repeat (3) begin
            pulse();
            frame(1'b0);
         end
      end
      summarize();
   end
   // a stalled frame or strobe loop would otherwise run forever
   initial begin
      #400000;
      fail_count++;
      summarize();
   end
endmodule
